//--- hw/afd_cause_if.sv
// interface carrying the detected fault cause between the modules
`timescale 1ns/1ps
interface afd_cause_if;
  logic overflow;
  logic zero_divide;
  modport src (output overflow, output zero_divide);
  modport dst (input overflow, input zero_divide);
endinterface

//--- hw/afd_classify.sv
// combinational fault cause classifier
`timescale 1ns/1ps
`include "afd_regs.svh"
module afd_classify #(
  parameter int WIDTH = 32
) (
  input wire logic valid, // instruction issued
  input wire afd_pkg::afd_op_t op, // instruction class
  input wire logic [WIDTH-1:0] divisor, // divisor operand
  input wire logic range_exceeded, // result does not fit destination
  input wire logic overflow_mask, // overflow mask bit
  afd_cause_if.src cause // detected causes
);
  // only integer classes and the ordinal divide count; float reaches here but decodes as neither
  wire logic is_int = (op == afd_pkg::AFD_OP_INT_ARITH) || (op == afd_pkg::AFD_OP_INT_DIV);
  wire logic is_div = (op == afd_pkg::AFD_OP_INT_DIV) || (op == afd_pkg::AFD_OP_ORD_DIV);
  wire logic div_zero = valid && is_div && (divisor == '0);
  // zero divide wins: the divide never produces a result to overflow
  assign cause.zero_divide = div_zero;
  assign cause.overflow = valid && is_int && range_exceeded && !overflow_mask && !div_zero;
endmodule

//--- hw/afd_pkg.sv
// types for the arithmetic fault detection block
package afd_pkg;
  typedef enum logic [2:0]
  {
    AFD_OP_OTHER = 3'h0,
    AFD_OP_INT_ARITH = 3'h1,
    AFD_OP_ORD_ARITH = 3'h2,
    AFD_OP_INT_DIV = 3'h3,
    AFD_OP_ORD_DIV = 3'h4,
    AFD_OP_FLOAT = 3'h5
  } afd_op_t;
endpackage

//--- hw/afd_regs.svh
// constants for the arithmetic fault detection block
`ifndef AFD_REGS_SVH
`define AFD_REGS_SVH
`define AFD_FAULT_TYPE_NONE 4'h0
`define AFD_FAULT_TYPE_ARITH 4'h3
`define AFD_SUBTYPE_NONE 4'h0
`define AFD_SUBTYPE_OVERFLOW 4'h1
`define AFD_SUBTYPE_ZERO_DIVIDE 4'h2
`define AFD_RET_REG_INDEX 5'h02
`endif

//--- hw/afd_top.sv
// arithmetic fault detection and fault record generation
`timescale 1ns/1ps
`include "afd_regs.svh"
module afd_top #(
  parameter int WIDTH = 32, // destination width
  parameter int FULL_WIDTH = 64, // full result width
  parameter int AW = 32 // instruction address width
) (
  input wire logic clk, // 125 MHz clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic valid, // instruction issued this cycle
  input wire afd_pkg::afd_op_t op, // instruction class
  input wire logic [WIDTH-1:0] divisor, // divisor operand
  input wire logic [FULL_WIDTH-1:0] full_result, // infinitely wide result
  input wire logic range_exceeded, // result overflows destination
  input wire logic [4:0] dest_reg, // destination register index
  input wire logic [AW-1:0] inst_addr, // faulting instruction address
  input wire logic [AW-1:0] next_addr, // following instruction address
  input wire logic overflow_mask, // arithmetic control overflow mask
  output logic wr_en, // destination write strobe
  output logic [4:0] wr_reg, // destination register
  output logic [WIDTH-1:0] wr_data, // destination data
  output logic fault, // fault signal pulse
  output logic [3:0] fault_type, // record type field
  output logic [3:0] fault_subtype, // record subtype field
  output logic [AW-1:0] fault_addr, // record address field
  output logic [7:0] fault_flags, // record flags, unused
  output logic [31:0] fault_data, // record data, unused
  output logic saved_wr_en, // save strobe into frame r2
  output logic [4:0] saved_reg, // frame register index
  output logic [AW-1:0] saved_return_pointer, // saved return address
  output logic restartable // fault leaves state untouched
);
  afd_cause_if cause_bus ();

  afd_classify #(.WIDTH(WIDTH)) u_classify (
    .valid(valid),
    .op(op),
    .divisor(divisor),
    .range_exceeded(range_exceeded),
    .overflow_mask(overflow_mask),
    .cause(cause_bus.src)
  );

  // a result write happens for any class except other and float unless the divide faulted
  wire logic is_alu = (op != afd_pkg::AFD_OP_OTHER) && (op != afd_pkg::AFD_OP_FLOAT);
  wire logic do_write = valid && is_alu && !cause_bus.zero_divide;
  wire logic [WIDTH-1:0] trunc = full_result[WIDTH-1:0];
  // overflow fault is held one cycle so the write lands first
  logic ovf_pend;
  logic [AW-1:0] ovf_addr;
  logic [AW-1:0] ovf_next;
  wire logic zd_now = cause_bus.zero_divide;

  // destination write path
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_en <= 1'b0;
      wr_reg <= 5'h00;
      wr_data <= '0;
    end
    else if (ce)
    begin
      wr_en <= do_write;
      wr_reg <= dest_reg;
      wr_data <= trunc;
    end
  end

  // capture overflow for signalling after the write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ovf_pend <= 1'b0;
      ovf_addr <= '0;
      ovf_next <= '0;
    end
    else if (ce)
    begin
      ovf_pend <= cause_bus.overflow;
      ovf_addr <= inst_addr;
      ovf_next <= next_addr;
    end
  end

  // fault record; zero divide fires at once, overflow a cycle after its write
  wire logic fire = zd_now || ovf_pend;
  // a pending overflow takes precedence over a new zero divide the same cycle;
  // that zero divide is dropped, a limit of keeping a single record
  wire logic sel_ovf = ovf_pend;
  wire logic load_record = ce && fire;
  wire logic [3:0] next_sub = sel_ovf ? `AFD_SUBTYPE_OVERFLOW : `AFD_SUBTYPE_ZERO_DIVIDE;
  wire logic [AW-1:0] next_fault_addr = sel_ovf ? ovf_addr : inst_addr;
  wire logic [AW-1:0] next_return = sel_ovf ? ovf_next : next_addr;
  wire logic next_restartable = !sel_ovf;

  // fault strobe, one enabled cycle per reported fault; held while ce is low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault <= 1'b0;
    end
    else if (ce)
    begin
      fault <= fire;
    end
  end

  // frame save strobe travels with the fault strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      saved_wr_en <= 1'b0;
    end
    else if (ce)
    begin
      saved_wr_en <= fire;
    end
  end

  // type field; only the arithmetic type is ever produced here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_type <= `AFD_FAULT_TYPE_NONE;
    end
    else if (load_record)
    begin
      fault_type <= `AFD_FAULT_TYPE_ARITH;
    end
  end

  // subtype field; reserved codes cannot come out of the select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_subtype <= `AFD_SUBTYPE_NONE;
    end
    else if (load_record)
    begin
      fault_subtype <= next_sub;
    end
  end

  // address of the faulting instruction
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_addr <= '0;
    end
    else if (load_record)
    begin
      fault_addr <= next_fault_addr;
    end
  end

  // flags and data carry no meaning; kept at zero so handlers see a clean record
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fault_flags <= 8'h00;
      fault_data <= 32'h0000_0000;
    end
    else if (load_record)
    begin
      fault_flags <= 8'h00;
      fault_data <= 32'h0000_0000;
    end
  end

  // the return pointer always goes to frame register r2
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      saved_reg <= `AFD_RET_REG_INDEX;
    end
    else if (ce)
    begin
      saved_reg <= `AFD_RET_REG_INDEX;
    end
  end

  // address of the instruction that would have run next
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      saved_return_pointer <= '0;
    end
    else if (load_record)
    begin
      saved_return_pointer <= next_return;
    end
  end

  // overflow already wrote its destination, so only zero divide can be rerun
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      restartable <= 1'b0;
    end
    else if (load_record)
    begin
      restartable <= next_restartable;
    end
  end
endmodule

//--- tb/afd_top_monitor.sv
// assertion checker for the arithmetic fault block
`timescale 1ns/1ps
module afd_top_monitor #(parameter int WIDTH = 32) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic ce, // enable
  input wire logic valid, // issue
  input wire afd_pkg::afd_op_t op, // class
  input wire logic [WIDTH-1:0] divisor, // divisor
  input wire logic range_exceeded, // too wide
  input wire logic overflow_mask, // mask
  input wire logic wr_en, // write
  input wire logic fault, // fault
  input wire logic [3:0] fault_type, // type
  input wire logic [3:0] fault_subtype, // subtype
  input wire logic saved_wr_en, // save
  input wire logic [4:0] saved_reg, // frame reg
  input wire logic restartable // restart
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // issue decodes; zero divide wins over overflow on one divide
  wire t = ce && valid;
  wire zd = t && op inside {3'h3, 3'h4} && divisor == '0;
  wire ov = t && op inside {3'h1, 3'h3} && range_exceeded && !overflow_mask && !zd;
  wire mk = t && op == 3'h1 && range_exceeded && overflow_mask;
  wire nf = t && op inside {3'h0, 3'h2, 3'h5};
  // overflow waiting for its report; ce low holds it like the block does
  logic pend;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pend <= 1'b0;
    else if (ce)
      pend <= ov;
  end
  // a zero divide that meets a pending overflow is lost, so it is left out
  property p_zd; zd && !pend |=> fault && fault_subtype == 4'h2 && restartable && !wr_en; endproperty
  a_zd: assert property (p_zd) else $error("zero divide not reported");
  property p_ov; ov ##1 ce |-> wr_en ##1 (fault && fault_subtype == 4'h1 && !restartable); endproperty
  a_ov: assert property (p_ov) else $error("overflow not reported");
  property p_type; fault |-> fault_type == 4'h3; endproperty
  a_type: assert property (p_type) else $error("bad fault type");
  property p_sub; fault |-> fault_subtype inside {4'h1, 4'h2}; endproperty
  a_sub: assert property (p_sub) else $error("reserved subtype");
  property p_nf; nf && !pend |=> !fault; endproperty
  a_nf: assert property (p_nf) else $error("fault from other class");
  property p_mk; mk ##1 ce |-> wr_en ##1 (!fault || fault_subtype == 4'h2); endproperty
  a_mk: assert property (p_mk) else $error("masked overflow faulted");
  property p_save; fault |-> saved_wr_en && saved_reg == 5'h02; endproperty
  a_save: assert property (p_save) else $error("return pointer not saved");
  property p_ord; fault && !restartable && $past(ce) |-> $past(wr_en); endproperty
  a_ord: assert property (p_ord) else $error("overflow before write");
endmodule
bind afd_top afd_top_monitor #(.WIDTH(WIDTH)) afd_top_monitor_inst (.clk(clk), .rst(rst),
  .ce(ce), .valid(valid), .op(op), .divisor(divisor), .range_exceeded(range_exceeded),
  .overflow_mask(overflow_mask), .wr_en(wr_en), .fault(fault), .fault_type(fault_type),
  .fault_subtype(fault_subtype), .saved_wr_en(saved_wr_en), .saved_reg(saved_reg),
  .restartable(restartable));

//--- tb/tb_top.sv
// bench for the arithmetic fault block
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, valid = 1'b0, re = 1'b0, mask = 1'b0;
  afd_pkg::afd_op_t op = afd_pkg::AFD_OP_OTHER;
  logic [31:0] dv = 32'h0, ia = 32'h100, na = 32'h104, fa, srp, fdat;
  logic [63:0] fr = 64'h0123456789ABCDEF;
  logic [4:0] dr = 5'h05, wreg, sreg;
  logic [31:0] wdat;
  logic [7:0] ffl;
  logic [3:0] ft, fst;
  logic wen, flt, swen, rs;
  int miscompares = 0, cmp_count = 0;
  // free running clock at 125 MHz
  always #4 clk = ~clk;
  afd_top afd_top_inst (.clk(clk), .rst(rst), .ce(ce), .valid(valid), .op(op), .divisor(dv),
    .full_result(fr), .range_exceeded(re), .dest_reg(dr), .inst_addr(ia), .next_addr(na),
    .overflow_mask(mask), .wr_en(wen), .wr_reg(wreg), .wr_data(wdat), .fault(flt),
    .fault_type(ft), .fault_subtype(fst), .fault_addr(fa), .fault_flags(ffl),
    .fault_data(fdat), .saved_wr_en(swen), .saved_reg(sreg), .saved_return_pointer(srp),
    .restartable(rs));
  // compare one result, padded to 64 bits
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one instruction for one cycle; returns at the first settled sample
  task automatic issue(input logic [2:0] o, input logic [31:0] d, input logic r, input logic m);
    @(negedge clk);
    op = afd_pkg::afd_op_t'(o);
    dv = d;
    re = r;
    mask = m;
    ia = ia + 32'h10;
    na = ia + 32'h4;
    fr = {fr[31:0], ~fr[63:32]};
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
  endtask
  // unmasked overflow on both integer classes: write first, fault one cycle later
  task automatic t_ovf();
    for (int o = 1; o <= 3; o += 2)
    begin
      issue(3'(o), 32'h7, 1'b1, 1'b0);
      chk(wen, 1);
      chk({wreg, wdat}, {dr, fr[31:0]});
      chk(flt, 0);
      @(negedge clk);
      chk({flt, ft, fst, rs}, {1'b1, 4'h3, 4'h1, 1'b0});
      chk({fa, srp}, {ia, na});
      chk({ffl, fdat}, 0);
    end
  endtask
  // clock enable low holds a pending overflow, then holds the raised fault
  task automatic t_stall();
    issue(3'h1, 32'h5, 1'b1, 1'b0);
    chk(wen, 1);
    ce = 1'b0;
    @(negedge clk);
    chk({flt, wen}, 2'b01);
    ce = 1'b1;
    @(negedge clk);
    chk({flt, fst, rs}, {1'b1, 4'h1, 1'b0});
    chk({fa, srp}, {ia, na});
    ce = 1'b0;
    @(negedge clk);
    chk(flt, 1);
    ce = 1'b1;
  endtask
  // both divide kinds with zero divisor, range flag set to tempt overflow
  task automatic t_zdiv();
    for (int o = 3; o <= 4; o++)
    begin
      issue(3'(o), 32'h0, 1'b1, 1'b0);
      chk({flt, wen, ft, fst, rs}, {2'b10, 4'h3, 4'h2, 1'b1});
      chk({fa, srp, swen, sreg}, {ia, na, 1'b1, 5'h02});
    end
  endtask
  // masked overflow writes but never faults
  task automatic t_mask();
    issue(3'h1, 32'h3, 1'b1, 1'b1);
    chk({wen, wdat}, {1'b1, fr[31:0]});
    @(negedge clk);
    chk(flt, 0);
  endtask
  // other, ordinal arithmetic and float classes stay silent
  task automatic t_none();
    logic [2:0] cls [3] = '{3'h0, 3'h2, 3'h5};
    for (int i = 0; i < 3; i++)
    begin
      issue(cls[i], 32'h0, 1'b1, 1'b0);
      chk(flt, 0);
      @(negedge clk);
      chk(flt, 0);
    end
  endtask
  task automatic test_done();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // reset, then every scenario back to back
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_ovf();
    t_zdiv();
    t_mask();
    t_none();
    t_stall();
    test_done();
  end
endmodule
